// ---- rtl/fwp_pkg.sv ----
// package: register map, fields and types for the flash write-protect block
`default_nettype none
package fwp_pkg;
	// register offsets (byte addresses)
	localparam logic [12:0] OFF_IDX       = 13'h1020;
	localparam logic [12:0] OFF_PROT_A    = 13'h11d0;
	localparam logic [12:0] OFF_PROT_B    = 13'h11d4;
	localparam logic [12:0] OFF_PROT_C    = 13'h11d8;
	localparam logic [12:0] OFF_PROT_NM   = 13'h1210;
	localparam logic [12:0] OFF_STAT      = 13'h13d0;
	localparam logic [12:0] OFF_CMD       = 13'h1300;
	localparam logic [12:0] OFF_ADDR      = 13'h1304;
	localparam logic [12:0] OFF_STATIC_A  = 13'h1310;
	localparam logic [12:0] OFF_STATIC_B  = 13'h1314;
	localparam logic [12:0] OFF_STATIC_C  = 13'h1318;
	localparam logic [12:0] OFF_STATIC_NM = 13'h131c;
	localparam logic [12:0] OFF_STATIC_D  = 13'h1320;
	localparam logic [12:0] OFF_SWAP      = 13'h1330;
	localparam logic [12:0] OFF_ECC       = 13'h1334;
	localparam logic [12:0] OFF_PROT_D    = 13'h11dc;
	// reset values: one means protected
	localparam logic [31:0] PROT_ALL      = 32'hffffffff;
	localparam logic [31:0] ZERO_WORD     = 32'h00000000;
	// status bit positions
	localparam int ST_DONE    = 0;
	localparam int ST_PASS    = 1;
	localparam int ST_BUSY    = 2;
	localparam int ST_WEPFAIL = 4;
	// command field positions
	localparam int CMD_GO     = 0;
	localparam int CMD_ERASE  = 1;
	localparam int CMD_BANKER = 2;
	localparam int CMD_NM     = 3;
	localparam int CMD_DATA   = 4;
	localparam int CMD_BANK_L = 8;
	// address layout: sector index within the bank region
	localparam int SEC_LSB    = 10;
	localparam int SEC_W      = 9;
	localparam int GRP_LSB    = 3;
	localparam int LOW_SECS   = 32;
	localparam int B0_B_SKIP  = 4;
	localparam int OP_CYCLES  = 4;
	localparam int IDX_DONE   = 0;
	typedef struct packed {
		logic [12:0] addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} fwp_bus_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CHECK = 2'b01,
		ST_RUN = 2'b10,
		ST_END = 2'b11
	} fwp_state_t;
endpackage : fwp_pkg
`default_nettype wire

// ---- rtl/fwp_ctrl.sv ----
// flash write-protect checker, bank-swap mapping and ecc reporting
//
// Implementation choices: strobed register access and the register offsets.
`default_nettype none
module fwp_ctrl #(
	parameter int BANK_AW = 18
) (
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic [12:0] i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [31:0] o_rdata,
	input  wire logic        i_boot_load,
	input  wire logic        i_swap_req,
	input  wire logic [31:0] i_sys_addr,
	input  wire logic        i_ecc_sec,
	input  wire logic        i_ecc_ded,
	output logic             o_irq,
	output logic             o_sector_write,
	output logic [fwp_pkg::SEC_W-1:0] o_sector,
	output logic [31:0]      o_phys_addr,
	output logic             o_swap_done
);
	localparam int SEC_W_P = fwp_pkg::SEC_W;
	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	fwp_pkg::fwp_bus_t bus;
	assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
	wire w_prot_a  = bus.wr && bus.addr == fwp_pkg::OFF_PROT_A;
	wire w_prot_b  = bus.wr && bus.addr == fwp_pkg::OFF_PROT_B;
	wire w_prot_c  = bus.wr && bus.addr == fwp_pkg::OFF_PROT_C;
	wire w_prot_d  = bus.wr && bus.addr == fwp_pkg::OFF_PROT_D;
	wire w_prot_nm = bus.wr && bus.addr == fwp_pkg::OFF_PROT_NM;
	wire w_cmd     = bus.wr && bus.addr == fwp_pkg::OFF_CMD;
	wire w_addr    = bus.wr && bus.addr == fwp_pkg::OFF_ADDR;
	wire w_stat    = bus.wr && bus.addr == fwp_pkg::OFF_STAT;
	wire w_ecc     = bus.wr && bus.addr == fwp_pkg::OFF_ECC;
	// static words writable only while the synchronised boot window is open
	wire w_sa  = bus.wr && bus.addr == fwp_pkg::OFF_STATIC_A;
	wire w_sb  = bus.wr && bus.addr == fwp_pkg::OFF_STATIC_B;
	wire w_sc  = bus.wr && bus.addr == fwp_pkg::OFF_STATIC_C;
	wire w_sd  = bus.wr && bus.addr == fwp_pkg::OFF_STATIC_D;
	wire w_snm = bus.wr && bus.addr == fwp_pkg::OFF_STATIC_NM;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [31:0] prot_a_reg, prot_b_reg, prot_c_reg, prot_d_reg, prot_nm_reg;
	logic [31:0] st_a_reg, st_b_reg, st_c_reg, st_d_reg, st_nm_reg;
	logic [31:0] cmd_reg, addr_reg, stat_reg, ecc_reg, rdata_reg;
	logic        irq_reg, swap_reg, swap_done_reg, sec_wr_reg;
	logic        boot_s1_reg, boot_s2_reg, swap_s1_reg, swap_s2_reg;
	logic        sec_s1_reg, sec_s2_reg, ded_s1_reg, ded_s2_reg;
	logic [SEC_W_P-1:0] sec_reg, last_sec_reg;
	logic [31:0] phys_reg;
	logic [2:0]  cnt_reg;
	fwp_pkg::fwp_state_t state_reg, state_next;

	// ------------------------------------------------------------
	// protection lookup
	// ------------------------------------------------------------
	// one means protected
	function automatic logic prot_bit(
		input logic [2:0] bank, input logic nm, input logic data,
		input logic [SEC_W_P-1:0] s,
		input logic [31:0] a, input logic [31:0] b, input logic [31:0] c,
		input logic [31:0] d, input logic [31:0] n);
		logic [5:0] g;
		g = 6'(s >> fwp_pkg::GRP_LSB);
		if (nm)
			return n[0];
		if (data)
			return d[s[4:0]];
		if (s[8])
			return c[g[4:0]];
		if (bank == 3'h0) begin
			if (s < 9'(fwp_pkg::LOW_SECS))
				return a[s[4:0]];
			return b[g[4:0]];
		end
		return b[g[4:0]];
	endfunction : prot_bit

	wire [2:0]  op_bank = cmd_reg[fwp_pkg::CMD_BANK_L +: 3];
	wire        op_nm   = cmd_reg[fwp_pkg::CMD_NM];
	wire        op_data = cmd_reg[fwp_pkg::CMD_DATA] && op_bank != 3'h0;
	wire        op_bank_er = cmd_reg[fwp_pkg::CMD_BANKER];
	// dynamic mask taken for addressed bank
	wire dyn_hit = prot_bit(op_bank, op_nm, op_data, sec_reg,
		prot_a_reg, prot_b_reg, prot_c_reg, prot_d_reg, prot_nm_reg);
	wire sta_hit = prot_bit(op_bank, op_nm, op_data, sec_reg,
		st_a_reg, st_b_reg, st_c_reg, st_d_reg, st_nm_reg);
	wire hit = dyn_hit | sta_hit;
	wire last_sec = op_nm || !op_bank_er || sec_reg == last_sec_reg;
	wire go = w_cmd && bus.wdata[fwp_pkg::CMD_GO] && state_reg == fwp_pkg::ST_IDLE;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			fwp_pkg::ST_IDLE:  if (go) state_next = fwp_pkg::ST_CHECK;
			fwp_pkg::ST_CHECK: state_next = fwp_pkg::ST_RUN;
			fwp_pkg::ST_RUN:   if (cnt_reg == 3'(fwp_pkg::OP_CYCLES - 1))
				state_next = last_sec ? fwp_pkg::ST_END : fwp_pkg::ST_CHECK;
			fwp_pkg::ST_END:   state_next = fwp_pkg::ST_IDLE;
			default:           state_next = fwp_pkg::ST_IDLE;
		endcase
	end

	// ------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------
	logic [31:0] rmux;
	always_comb begin
		case (bus.addr)
			fwp_pkg::OFF_IDX:       rmux = ZW(stat_reg[fwp_pkg::ST_DONE]);
			fwp_pkg::OFF_PROT_A:    rmux = prot_a_reg;
			fwp_pkg::OFF_PROT_B:    rmux = prot_b_reg;
			fwp_pkg::OFF_PROT_C:    rmux = prot_c_reg;
			fwp_pkg::OFF_PROT_D:    rmux = prot_d_reg;
			fwp_pkg::OFF_PROT_NM:   rmux = prot_nm_reg;
			fwp_pkg::OFF_STAT:      rmux = stat_reg;
			fwp_pkg::OFF_CMD:       rmux = cmd_reg;
			fwp_pkg::OFF_ADDR:      rmux = addr_reg;
			fwp_pkg::OFF_STATIC_A:  rmux = st_a_reg;
			fwp_pkg::OFF_STATIC_B:  rmux = st_b_reg;
			fwp_pkg::OFF_STATIC_C:  rmux = st_c_reg;
			fwp_pkg::OFF_STATIC_D:  rmux = st_d_reg;
			fwp_pkg::OFF_STATIC_NM: rmux = st_nm_reg;
			fwp_pkg::OFF_SWAP:      rmux = {30'h0, swap_done_reg, swap_reg};
			fwp_pkg::OFF_ECC:       rmux = ecc_reg;
			default:                rmux = fwp_pkg::ZERO_WORD;
		endcase
	end
	function automatic logic [31:0] ZW(input logic b);
		return {31'h0, b};
	endfunction : ZW

	// ------------------------------------------------------------
	// swap translation
	// ------------------------------------------------------------
	// flip bank bit of main range
	wire [31:0] bank_bit = 32'h1 << BANK_AW;
	wire [31:0] phys_next = (swap_reg && i_sys_addr < (bank_bit << 1)) ? (i_sys_addr ^ bank_bit) : i_sys_addr;

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		// synchronisers for pin-level inputs
		boot_s1_reg <= i_boot_load;
		boot_s2_reg <= boot_s1_reg;
		swap_s1_reg <= i_swap_req;
		swap_s2_reg <= swap_s1_reg;
		sec_s1_reg  <= i_ecc_sec;
		sec_s2_reg  <= sec_s1_reg;
		ded_s1_reg  <= i_ecc_ded;
		ded_s2_reg  <= ded_s1_reg;
		phys_reg    <= phys_next;
		rdata_reg   <= bus.rd ? rmux : fwp_pkg::ZERO_WORD;
		if (i_rst) begin
			prot_a_reg <= fwp_pkg::PROT_ALL;
			prot_b_reg <= fwp_pkg::PROT_ALL;
			prot_c_reg <= fwp_pkg::PROT_ALL;
			prot_d_reg <= fwp_pkg::PROT_ALL;
			prot_nm_reg <= fwp_pkg::PROT_ALL;
			st_a_reg <= fwp_pkg::ZERO_WORD;
			st_b_reg <= fwp_pkg::ZERO_WORD;
			st_c_reg <= fwp_pkg::ZERO_WORD;
			st_d_reg <= fwp_pkg::ZERO_WORD;
			st_nm_reg <= fwp_pkg::ZERO_WORD;
			cmd_reg <= fwp_pkg::ZERO_WORD;
			addr_reg <= fwp_pkg::ZERO_WORD;
			stat_reg <= fwp_pkg::ZERO_WORD;
			ecc_reg <= fwp_pkg::ZERO_WORD;
			irq_reg <= 1'b0;
			swap_reg <= 1'b0;
			swap_done_reg <= 1'b0;
			sec_wr_reg <= 1'b0;
			sec_reg <= '0;
			last_sec_reg <= '0;
			cnt_reg <= 3'h0;
			state_reg <= fwp_pkg::ST_IDLE;
		end else begin
			state_reg <= state_next;
			if (w_prot_a) prot_a_reg <= bus.wdata;
			if (w_prot_b) prot_b_reg <= bus.wdata;
			if (w_prot_c) prot_c_reg <= bus.wdata;
			if (w_prot_d) prot_d_reg <= bus.wdata;
			if (w_prot_nm) prot_nm_reg <= bus.wdata;
			if (w_sa && boot_s2_reg) st_a_reg <= st_a_reg | bus.wdata;
			if (w_sb && boot_s2_reg) st_b_reg <= st_b_reg | bus.wdata;
			if (w_sc && boot_s2_reg) st_c_reg <= st_c_reg | bus.wdata;
			if (w_sd && boot_s2_reg) st_d_reg <= st_d_reg | bus.wdata;
			if (w_snm && boot_s2_reg) st_nm_reg <= st_nm_reg | bus.wdata;
			if (w_addr && state_reg == fwp_pkg::ST_IDLE) addr_reg <= bus.wdata;
			// sticky ecc flags, set wins over clear
			ecc_reg[0] <= sec_s2_reg | (ecc_reg[0] & ~(w_ecc & bus.wdata[0]));
			ecc_reg[1] <= ded_s2_reg | (ecc_reg[1] & ~(w_ecc & bus.wdata[1]));
			if (swap_s2_reg && !swap_reg) begin
				swap_reg <= 1'b1;
				swap_done_reg <= 1'b1;
			end
			irq_reg <= 1'b0;
			sec_wr_reg <= 1'b0;
			if (go) begin
				cmd_reg <= bus.wdata;
				sec_reg <= addr_reg[fwp_pkg::SEC_LSB +: SEC_W_P];
				last_sec_reg <= '1;
				stat_reg <= 32'h1 << fwp_pkg::ST_BUSY;
				cnt_reg <= 3'h0;
			end else if (w_stat && state_reg == fwp_pkg::ST_IDLE) begin
				stat_reg[fwp_pkg::ST_DONE] <= 1'b0;
			end
			if (state_reg == fwp_pkg::ST_CHECK) begin
				cnt_reg <= 3'h0;
				if (hit)
					stat_reg[fwp_pkg::ST_WEPFAIL] <= 1'b1;
				else
					sec_wr_reg <= 1'b1;
			end
			if (state_reg == fwp_pkg::ST_RUN) begin
				cnt_reg <= cnt_reg + 3'h1;
				if (cnt_reg == 3'(fwp_pkg::OP_CYCLES - 1) && !last_sec)
					sec_reg <= sec_reg + 9'h1;
			end
			if (state_reg == fwp_pkg::ST_END) begin
				stat_reg[fwp_pkg::ST_DONE] <= 1'b1;
				stat_reg[fwp_pkg::ST_PASS] <= ~stat_reg[fwp_pkg::ST_WEPFAIL];
				stat_reg[fwp_pkg::ST_BUSY] <= 1'b0;
				irq_reg <= 1'b1;
				prot_a_reg <= fwp_pkg::PROT_ALL;
				prot_b_reg <= fwp_pkg::PROT_ALL;
				prot_c_reg <= fwp_pkg::PROT_ALL;
				prot_d_reg <= fwp_pkg::PROT_ALL;
				prot_nm_reg <= fwp_pkg::PROT_ALL;
			end
		end
	end

	assign o_rdata        = rdata_reg;
	assign o_irq          = irq_reg;
	assign o_sector_write = sec_wr_reg;
	assign o_sector       = sec_reg;
	assign o_phys_addr    = phys_reg;
	assign o_swap_done    = swap_done_reg;
endmodule : fwp_ctrl
`default_nettype wire

// ---- test/fwp_ctrl_props.sv ----
// port assertions for the flash write-protect block
`default_nettype none
module fwp_ctrl_props #(
	parameter int BANK_AW = 18
) (
	input wire logic        i_clk,
	input wire logic        i_rst,
	input wire logic [12:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic        i_wr,
	input wire logic        i_rd,
	input wire logic [31:0] o_rdata,
	input wire logic        i_boot_load,
	input wire logic        i_swap_req,
	input wire logic [31:0] i_sys_addr,
	input wire logic        i_ecc_sec,
	input wire logic        i_ecc_ded,
	input wire logic        o_irq,
	input wire logic        o_sector_write,
	input wire logic [8:0]  o_sector,
	input wire logic [31:0] o_phys_addr,
	input wire logic        o_swap_done
);
	localparam logic [31:0] SPAN = 32'h1 << BANK_AW;
	logic      busy_reg;
	wire logic busy_next;
	wire logic go_w;
	// ------------------------------------------------
	// operation tracking
	// ------------------------------------------------
	assign go_w      = i_wr && (i_addr == fwp_pkg::OFF_CMD) && i_wdata[fwp_pkg::CMD_GO];
	assign busy_next = o_irq ? 1'b0 : (go_w | busy_reg);
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			busy_reg <= 1'b0;
		end else begin
			busy_reg <= busy_next;
		end
	end
	// ------------------------------------------------
	// port relations
	// ------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	a_irq_pulse: assert property (o_irq |=> !o_irq)
		else $error("irq wider than one cycle");
	a_op_ends: assert property (go_w && !busy_reg && !i_wdata[fwp_pkg::CMD_BANKER] |-> ##[5:9] o_irq)
		else $error("operation did not end in time");
	a_write_in_op: assert property (o_sector_write |-> busy_reg)
		else $error("sector write outside an operation");
	a_write_pulse: assert property (o_sector_write |=> !o_sector_write)
		else $error("sector write wider than one cycle");
	a_rdata_quiet: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
		else $error("read data without a read");
	a_swap_reset: assert property ($past(i_rst) |-> !o_swap_done)
		else $error("swap shown right after reset");
	a_swap_sticky: assert property (o_swap_done |=> o_swap_done)
		else $error("swap dropped");
	a_map_direct: assert property (!$past(i_rst) && !o_swap_done && !$past(o_swap_done)
		&& $past(i_sys_addr) < 2 * SPAN |-> o_phys_addr == $past(i_sys_addr))
		else $error("unswapped mapping wrong");
	a_map_swap: assert property ($past(o_swap_done) && o_swap_done
		&& $past(i_sys_addr) < 2 * SPAN |-> o_phys_addr == ($past(i_sys_addr) ^ SPAN))
		else $error("swapped mapping wrong");
endmodule : fwp_ctrl_props
bind fwp_ctrl fwp_ctrl_props #(.BANK_AW(BANK_AW)) u_props (
	.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
	.o_rdata(o_rdata), .i_boot_load(i_boot_load), .i_swap_req(i_swap_req), .i_sys_addr(i_sys_addr),
	.i_ecc_sec(i_ecc_sec), .i_ecc_ded(i_ecc_ded), .o_irq(o_irq), .o_sector_write(o_sector_write),
	.o_sector(o_sector), .o_phys_addr(o_phys_addr), .o_swap_done(o_swap_done)
);
`default_nettype wire

// ---- test/fwp_ctrl_bench.sv ----
// self-checking bench for the flash write-protect block
`default_nettype none
module fwp_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        i_clk, i_rst, i_wr, i_rd, i_boot_load, i_swap_req, i_ecc_sec, i_ecc_ded;
	logic        o_irq, o_sector_write, o_swap_done, rd_seen;
	logic [12:0] i_addr;
	logic [31:0] i_wdata, i_sys_addr, o_rdata, o_phys_addr, rnd;
	logic [8:0]  o_sector;
	logic [31:0] rd_q[$], sec_q[$];
	integer      seed;
	int          fails, check_count, cycles;
	localparam logic [31:0] OK_ST = (32'h1 << fwp_pkg::ST_DONE) | (32'h1 << fwp_pkg::ST_PASS);
	localparam logic [31:0] WP_ST = (32'h1 << fwp_pkg::ST_DONE) | (32'h1 << fwp_pkg::ST_WEPFAIL);
	localparam logic [12:0] RST_OFF [8] = '{fwp_pkg::OFF_PROT_A, fwp_pkg::OFF_PROT_B, fwp_pkg::OFF_PROT_C,
		fwp_pkg::OFF_PROT_NM, fwp_pkg::OFF_STATIC_A, fwp_pkg::OFF_STAT, fwp_pkg::OFF_SWAP, 13'h0ff0};
	localparam logic [31:0] RST_VAL [8] = '{32'hffffffff, 32'hffffffff, 32'hffffffff, 32'hffffffff,
		32'h0, 32'h0, 32'h0, 32'h0};
	fwp_ctrl i_dut (
		.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .i_boot_load(i_boot_load), .i_swap_req(i_swap_req), .i_sys_addr(i_sys_addr),
		.i_ecc_sec(i_ecc_sec), .i_ecc_ded(i_ecc_ded), .o_irq(o_irq), .o_sector_write(o_sector_write),
		.o_sector(o_sector), .o_phys_addr(o_phys_addr), .o_swap_done(o_swap_done)
	);
	always #50 i_clk = ~i_clk;
	// ------------------------------------------------
	// checking and bus tasks
	// ------------------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("FAIL %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task give_verdict;
		if (fails == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : give_verdict
	task automatic wr(input logic [12:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_addr  <= a;
		i_wdata <= d;
		i_wr    <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [12:0] a, input logic [31:0] e);
		rd_q.push_back(e);
		@(posedge i_clk);
		i_addr <= a;
		i_rd   <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
	endtask : rd
	// mask must be rewritten first: the block restores all-ones after each run
	task automatic op(input logic [8:0] s, input logic [2:0] b, input logic [12:0] r, input logic [31:0] m,
			input logic ok);
		wr(r, m);
		wr(fwp_pkg::OFF_ADDR, {13'h0, s, 10'h0});
		if (ok) sec_q.push_back({23'h0, s});
		wr(fwp_pkg::OFF_CMD, {21'h0, b, 8'h01});
		repeat (20) if (o_irq !== 1'b1) @(posedge i_clk);
		check("irq", {31'h0, o_irq}, 32'h1);
		rd(fwp_pkg::OFF_STAT, ok ? OK_ST : WP_ST);
		rd(r, fwp_pkg::PROT_ALL);
	endtask : op
	// ------------------------------------------------
	// monitor, timeout and sequence
	// ------------------------------------------------
	always @(posedge i_clk) begin
		if (rd_seen === 1'b1) check("rdata", o_rdata, rd_q.pop_front());
		if (o_sector_write === 1'b1) check("sector", {23'h0, o_sector}, sec_q.size() ? sec_q.pop_front() : 'x);
		rd_seen = i_rd;
	end
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			give_verdict();
		end
	end
	initial begin
		i_clk = 1'b0;
		i_rst = 1'b1;
		{i_wr, i_rd, i_boot_load, i_swap_req, i_ecc_sec, i_ecc_ded} = 6'h0;
		i_addr = 13'h0;
		i_wdata = 32'h0;
		i_sys_addr = 32'h0;
		rd_seen = 1'b0;
		seed = 32'h9d4f;
		repeat (10) @(posedge i_clk);
		i_rst <= 1'b0;
		foreach (RST_OFF[k]) rd(RST_OFF[k], RST_VAL[k]);
		rnd = $random(seed);
		wr(fwp_pkg::OFF_PROT_A, rnd);
		rd(fwp_pkg::OFF_PROT_A, rnd);
		op(9'd5, 3'd0, fwp_pkg::OFF_PROT_A, 32'h0, 1'b1);
		op(9'd5, 3'd0, fwp_pkg::OFF_PROT_A, 32'h20, 1'b0);
		op(9'd40, 3'd0, fwp_pkg::OFF_PROT_B, 32'hf, 1'b1);
		op(9'd40, 3'd0, fwp_pkg::OFF_PROT_A, 32'h0, 1'b0);
		op(9'd3, 3'd1, fwp_pkg::OFF_PROT_B, 32'hfffffffe, 1'b1);
		op(9'd3, 3'd0, fwp_pkg::OFF_PROT_B, 32'h0, 1'b0);
		op(9'd300, 3'd2, fwp_pkg::OFF_PROT_C, 32'hffffffdf, 1'b1);
		i_boot_load <= 1'b1;
		repeat (3) @(posedge i_clk);
		wr(fwp_pkg::OFF_STATIC_A, 32'h20);
		i_boot_load <= 1'b0;
		repeat (3) @(posedge i_clk);
		wr(fwp_pkg::OFF_STATIC_A, 32'h0);
		rd(fwp_pkg::OFF_STATIC_A, 32'h20);
		op(9'd5, 3'd0, fwp_pkg::OFF_PROT_A, 32'h0, 1'b0);
		rnd = {13'h0, 19'($random(seed))};
		i_sys_addr <= rnd;
		repeat (2) @(posedge i_clk);
		check("phys", o_phys_addr, rnd);
		i_sys_addr <= 32'h00100000;
		i_swap_req <= 1'b1;
		repeat (20) if (o_swap_done !== 1'b1) @(posedge i_clk);
		check("swap", {31'h0, o_swap_done}, 32'h1);
		i_sys_addr <= rnd;
		repeat (2) @(posedge i_clk);
		check("phys", o_phys_addr, rnd ^ 32'h00040000);
		i_ecc_sec <= 1'b1;
		i_ecc_ded <= 1'b1;
		repeat (3) @(posedge i_clk);
		i_ecc_sec <= 1'b0;
		i_ecc_ded <= 1'b0;
		repeat (3) @(posedge i_clk);
		rd(fwp_pkg::OFF_ECC, 32'h3);
		wr(fwp_pkg::OFF_ECC, 32'h3);
		rd(fwp_pkg::OFF_ECC, 32'h0);
		repeat (3) @(posedge i_clk);
		give_verdict();
	end
endmodule : fwp_ctrl_bench
`default_nettype wire
